// [sdc_chk.sv]
// Purpose: port checks of sdc_core
// Assumes: outputs follow the hand-over timing
// Notes:   bound to the core at the foot of this file
`default_nettype none
module sdc_chk #(
  parameter int MEM_ROW_BITS = 2
) (
  input wire logic                   mclk_i,
  input wire logic                   sys_rst_i,
  input wire logic                   cke_i,
  input wire sdc_pkg::sdc_cmd_pins_t cmd_i,
  input wire logic                   dqm_i,
  input wire logic [7:0]             dq_i,
  input wire logic [7:0]             dq_o,
  input wire logic                   dq_oe_n_o,
  input wire logic [3:0]             bank_open_o,
  input wire logic                   burst_active_o,
  input wire logic                   suspend_o,
  input wire logic                   power_down_o,
  input wire logic                   self_refresh_o,
  input wire logic                   busy_o,
  input wire logic                   illegal_o
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic [3:0] op;
  logic       live;
  logic       all_idle;
  assign op = {cmd_i.cs_n, cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n};
  // busy refuses non-nops, so only commands taken while idle are judged
  assign live = !suspend_o && !power_down_o && !self_refresh_o && !busy_o;
  assign all_idle = (bank_open_o == 4'h0) && !burst_active_o && !busy_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_one_busy;
    busy_o ##1 !busy_o;
  endsequence
  sequence s_act_ok;
    live && cke_i && op == 4'h3 && !bank_open_o[cmd_i.bank_sel];
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_act_opens_row: assert property (
    s_act_ok |=> bank_open_o[$past(cmd_i.bank_sel)]) else $error("row not opened");
  a_act_open_refused: assert property (
    live && op == 4'h3 && bank_open_o[cmd_i.bank_sel] |=> illegal_o) else $error("act ok");
  a_access_closed: assert property (
    live && (op == 4'h4 || op == 4'h5) && !bank_open_o[cmd_i.bank_sel] |=> illegal_o)
    else $error("access to closed bank taken");
  a_pre_all_banks: assert property (
    live && op == 4'h2 && cmd_i.addr[10] |=> bank_open_o == 4'h0) else $error("pre all");
  a_pre_one_bank: assert property (
    live && op == 4'h2 && !cmd_i.addr[10] |=> !bank_open_o[$past(cmd_i.bank_sel)])
    else $error("pre one");
  a_read_mask_late: assert property (
    (dqm_i && cke_i && !suspend_o) ##1 cke_i |-> ##1 dq_oe_n_o) else $error("mask late");
  a_pd_entry: assert property (
    live && cmd_i.cs_n && !cke_i && all_idle |=> power_down_o) else $error("no pd");
  a_pd_exit: assert property (
    power_down_o && cke_i |=> !power_down_o) else $error("pd kept");
  a_sr_entry: assert property (
    live && op == 4'h1 && !cke_i && all_idle |=> self_refresh_o) else $error("no sr");
  a_sr_hold: assert property (
    self_refresh_o && !cke_i |=> self_refresh_o) else $error("sr lost");
  a_suspend_in: assert property (
    live && !cke_i && bank_open_o != 4'h0 |=> suspend_o) else $error("no suspend");
  a_suspend_out: assert property (
    cke_i |=> !suspend_o) else $error("suspend kept");
  a_mrs_wait_two: assert property (
    live && cke_i && op == 4'h0 && all_idle |=> s_one_busy) else $error("mode set wait");
  a_ref_wait_rc: assert property (
    live && cke_i && op == 4'h1 && all_idle |=> s_one_busy) else $error("refresh wait");
endmodule : sdc_chk

bind sdc_core sdc_chk #(.MEM_ROW_BITS(MEM_ROW_BITS)) u_chk (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .cke_i(cke_i), .cmd_i(cmd_i),
  .dqm_i(dqm_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o),
  .bank_open_o(bank_open_o), .burst_active_o(burst_active_o), .suspend_o(suspend_o),
  .power_down_o(power_down_o), .self_refresh_o(self_refresh_o), .busy_o(busy_o),
  .illegal_o(illegal_o));
`default_nettype wire

// [sdc_cmd_dec.sv]
// Purpose: strobe decoder
// Assumes: pins sampled by the caller on the rising edge
// Notes:   purely combinational
`default_nettype none
module sdc_cmd_dec (
  input  wire sdc_pkg::sdc_cmd_pins_t pins_i,
  output var sdc_pkg::sdc_cmd_t       cmd_o
);
  wire [2:0] strobes = {pins_i.ras_n, pins_i.cas_n, pins_i.we_n};

  always_comb begin
    if (pins_i.cs_n) begin
      cmd_o = sdc_pkg::sdc_deselect;
    end else begin
      case (strobes)
        3'h0:    cmd_o = sdc_pkg::sdc_mode_set;
        3'h1:    cmd_o = sdc_pkg::sdc_refresh;
        3'h2:    cmd_o = sdc_pkg::sdc_precharge;
        3'h3:    cmd_o = sdc_pkg::sdc_activate;
        3'h4:    cmd_o = sdc_pkg::sdc_write;
        3'h5:    cmd_o = sdc_pkg::sdc_read;
        3'h6:    cmd_o = sdc_pkg::sdc_stop;
        default: cmd_o = sdc_pkg::sdc_nop;
      endcase
    end
  end
endmodule : sdc_cmd_dec
`default_nettype wire

// [sdc_core.sv]
// Purpose: command decode, bank tracking and clock gate handling
// Assumes: controller keeps its timing and ordering duties
// Notes:   only MEM_ROW_BITS of the row index the storage
`include "sdc_map.svh"
`default_nettype none
module sdc_core #(
  parameter int MEM_ROW_BITS = 2
) (
  input  wire logic                   mclk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   cke_i,
  input  wire sdc_pkg::sdc_cmd_pins_t cmd_i,
  input  wire logic                   dqm_i,
  input  wire logic [7:0]             dq_i,
  output logic      [7:0]             dq_o,
  output logic                        dq_oe_n_o,
  output logic      [3:0]             bank_open_o,
  output logic                        burst_active_o,
  output logic                        suspend_o,
  output logic                        power_down_o,
  output logic                        self_refresh_o,
  output logic                        busy_o,
  output logic                        illegal_o
);
  localparam int IDXW = 2 + MEM_ROW_BITS + 8;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0]              mem_q [2**IDXW];
  sdc_pkg::sdc_bank_st_t   bst_q [4];
  logic [11:0]             row_q [4];
  logic [3:0]              pcnt_q [4];
  logic [11:0]             mr_q;
  logic                    cke_q;
  logic                    pd_q;
  logic                    sr_q;
  logic [3:0]              gcnt_q;
  logic                    bact_q;
  logic                    bwr_q;
  logic                    bap_q;
  logic [1:0]              bbank_q;
  logic [7:0]              col_q;
  logic [8:0]              rem_q;
  logic                    dqm_d1_q;
  logic [7:0]              dq_q;
  logic                    oe_n_q;
  logic                    ill_q;
  sdc_pkg::sdc_cmd_t       cmd;
  sdc_pkg::sdc_rd_beat_t   pin;
  sdc_pkg::sdc_rd_beat_t   pout;
  logic [3:0]              bidle;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  sdc_cmd_dec u_dec (
    .pins_i (cmd_i),
    .cmd_o  (cmd)
  );

  // internal clock runs one edge behind the gate
  wire tick     = cke_q & ~pd_q & ~sr_q;
  wire gbusy    = gcnt_q != 4'h0;
  wire [1:0] bs = cmd_i.bank_sel;
  wire ap       = cmd_i.addr[`SDC_AP_BIT];
  wire is_nop   = (cmd == sdc_pkg::sdc_nop) | (cmd == sdc_pkg::sdc_deselect);
  wire is_act   = cmd == sdc_pkg::sdc_activate;
  wire is_acc   = (cmd == sdc_pkg::sdc_read) | (cmd == sdc_pkg::sdc_write);
  wire is_pre   = cmd == sdc_pkg::sdc_precharge;
  wire is_ref   = cmd == sdc_pkg::sdc_refresh;
  wire is_mrs   = cmd == sdc_pkg::sdc_mode_set;
  wire is_stop  = cmd == sdc_pkg::sdc_stop;
  wire sel_idle = bst_q[bs] == sdc_pkg::bk_idle;
  wire sel_open = bst_q[bs] == sdc_pkg::bk_active;
  wire all_idle = (&bidle) & ~bact_q & ~gbusy;

  // ----------------------------------------
  // legality
  // ----------------------------------------
  wire bad_act  = is_act & ~sel_idle;
  wire bad_acc  = is_acc & ~sel_open;
  wire bad_glob = (is_mrs | is_ref) & ~all_idle;
  wire bad_busy = gbusy & ~is_nop;
  wire bad_run  = tick & (bad_busy | (~gbusy & (bad_act | bad_acc | bad_glob)));
  wire bad_pdx  = pd_q & cke_i & ~cmd_i.cs_n;
  wire bad_srx  = sr_q & cke_i & ~is_nop;
  wire ok       = tick & ~gbusy;
  wire do_act   = ok & is_act & sel_idle;
  wire do_acc   = ok & is_acc & sel_open;
  wire do_pre   = ok & is_pre;
  wire do_stop  = ok & is_stop;
  wire do_ref   = ok & is_ref & all_idle;
  wire do_mrs   = ok & is_mrs & all_idle;
  wire pd_enter = ok & (cmd == sdc_pkg::sdc_deselect) & ~cke_i & all_idle;

  // ----------------------------------------
  // mode fields
  // ----------------------------------------
  wire [2:0] bl_f  = mr_q[`SDC_MR_BL_MSB:`SDC_MR_BL_LSB];
  wire [2:0] cl_f  = mr_q[`SDC_MR_CL_MSB:`SDC_MR_CL_LSB];
  wire       full  = bl_f == `SDC_BL_FULL;
  wire [8:0] blen  = full ? `SDC_PAGE_LEN : (9'h001 << bl_f[1:0]);
  wire [7:0] cmask = full ? 8'hFF : (blen[7:0] - 8'h01);
  wire       cl3   = cl_f == `SDC_CL3_CODE;

  // ----------------------------------------
  // burst engine
  // ----------------------------------------
  // a precharge only cuts the burst that runs in a bank it closes
  wire pre_burst = bact_q & do_pre & (ap | (bs == bbank_q));
  wire go_on     = bact_q & tick & ~do_stop & ~pre_burst & ~do_acc;
  wire acc_now   = do_acc | go_on;
  wire [1:0] acc_bank = do_acc ? bs : bbank_q;
  wire [7:0] acc_col  = do_acc ? cmd_i.addr[`SDC_COL_MSB:0] : col_q;
  wire       acc_wr   = do_acc ? (cmd == sdc_pkg::sdc_write) : bwr_q;
  wire       cur_ap   = do_acc ? ap : bap_q;
  wire [8:0] cur_rem  = do_acc ? blen : rem_q;
  wire       last     = ~full & (cur_rem == 9'h001);
  wire       ap_end   = acc_now & last & cur_ap;
  wire [7:0] col_inc  = acc_col + 8'h01;
  wire [7:0] col_nx   = (acc_col & ~cmask) | (col_inc & cmask);
  wire [11:0] acc_row = row_q[acc_bank];
  wire [IDXW-1:0] idx = {acc_bank, acc_row[MEM_ROW_BITS-1:0], acc_col};
  wire wr_en          = acc_now & acc_wr & ~dqm_i;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      bact_q  <= 1'b0;
      bwr_q   <= 1'b0;
      bap_q   <= 1'b0;
      bbank_q <= 2'h0;
      col_q   <= 8'h00;
      rem_q   <= 9'h000;
    end else if (acc_now) begin
      bact_q  <= ~last;
      bwr_q   <= acc_wr;
      bap_q   <= cur_ap;
      bbank_q <= acc_bank;
      col_q   <= col_nx;
      rem_q   <= cur_rem - 9'h001;
    end else if (do_stop | pre_burst) begin
      bact_q  <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (wr_en) begin
      mem_q[idx] <= dq_i;
    end
  end

  // ----------------------------------------
  // bank state
  // ----------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_bank
    wire close_g = (do_pre & (ap | (bs == 2'(g)))) | (ap_end & (acc_bank == 2'(g)));
    assign bidle[g]       = bst_q[g] == sdc_pkg::bk_idle;
    assign bank_open_o[g] = bst_q[g] == sdc_pkg::bk_active;

    always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
        bst_q[g]  <= sdc_pkg::bk_idle;
        row_q[g]  <= 12'h000;
        pcnt_q[g] <= 4'h0;
      end else begin
        case (bst_q[g])
          sdc_pkg::bk_idle: begin
            if (do_act & (bs == 2'(g))) begin
              bst_q[g] <= sdc_pkg::bk_active;
              row_q[g] <= cmd_i.addr;
            end
          end
          sdc_pkg::bk_active: begin
            if (close_g) begin
              bst_q[g]  <= (`SDC_RP_CYC > 1) ? sdc_pkg::bk_prech : sdc_pkg::bk_idle;
              pcnt_q[g] <= 4'(`SDC_RP_CYC - 1);
            end
          end
          sdc_pkg::bk_prech: begin
            pcnt_q[g] <= pcnt_q[g] - 4'h1;
            if (pcnt_q[g] <= 4'h1) begin
              bst_q[g] <= sdc_pkg::bk_idle;
            end
          end
          default: bst_q[g] <= sdc_pkg::bk_idle;
        endcase
      end
    end
  end

  // ----------------------------------------
  // mode, refresh and power states
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mr_q <= `SDC_MR_RST;
    end else if (do_mrs) begin
      mr_q <= cmd_i.addr;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      gcnt_q <= 4'h0;
    end else if (do_ref & cke_i) begin
      gcnt_q <= 4'(`SDC_RC_CYC - 1);
    end else if (do_mrs) begin
      gcnt_q <= 4'(`SDC_MRS_CYC - 1);
    end else if (gbusy & tick) begin
      gcnt_q <= gcnt_q - 4'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      cke_q <= 1'b1;
      pd_q  <= 1'b0;
      sr_q  <= 1'b0;
    end else begin
      cke_q <= cke_i;
      if (pd_q) begin
        pd_q <= ~cke_i;
      end else if (pd_enter) begin
        pd_q <= 1'b1;
      end
      if (sr_q) begin
        sr_q <= ~cke_i;
      end else if (do_ref & ~cke_i) begin
        sr_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // a cut burst stops feeding the line, so beats already queued still leave
  assign pin.valid = acc_now & ~acc_wr;
  assign pin.data  = mem_q[idx];

  sdc_rd_pipe #(
    .W     (9),
    .DEPTH (2)
  ) u_pipe (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .adv_i     (tick),
    .din_i     (pin),
    .sel_i     (cl3),
    .dout_o    (pout)
  );

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      dqm_d1_q <= 1'b0;
      dq_q     <= 8'h00;
      oe_n_q   <= 1'b1;
      ill_q    <= 1'b0;
    end else begin
      dqm_d1_q <= dqm_i;
      ill_q    <= bad_run | bad_pdx | bad_srx;
      if (tick) begin
        dq_q   <= pout.data;
        oe_n_q <= ~(pout.valid & ~dqm_d1_q);
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign dq_o           = dq_q;
  assign dq_oe_n_o      = oe_n_q;
  assign burst_active_o = bact_q;
  assign suspend_o      = ~cke_q & ~pd_q & ~sr_q;
  assign power_down_o   = pd_q;
  assign self_refresh_o = sr_q;
  assign busy_o         = gbusy;
  assign illegal_o      = ill_q;
endmodule : sdc_core
`default_nettype wire

// [sdc_ctl_model.sv]
// Purpose: memory controller side of the command bus
// Assumes: one command per 50 ns cycle, driven at the falling edge
// Notes:   timing duties are kept by the caller's command spacing
`default_nettype none
module sdc_ctl_model (
  input wire logic                   mclk_i,
  output var logic                   cke_o,
  output var sdc_pkg::sdc_cmd_pins_t cmd_o,
  output var logic                   dqm_o,
  output var logic [7:0]             dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cke_o = 1'b1;
    cmd_o = '0;
    cmd_o.cs_n = 1'b1;
    dqm_o = 1'b0;
    dq_o = 8'h5A;
  end
  // ----------------------------------------
  // one command cycle
  // ----------------------------------------
  // a 50 ns cycle meets every ns minimum with one cycle between commands
  // callers close all banks before power down, self refresh and mode set
  task step(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
            input logic k, input logic m, input logic [7:0] d);
    @(negedge mclk_i);
    cke_o = k;
    {cmd_o.cs_n, cmd_o.ras_n, cmd_o.cas_n, cmd_o.we_n} = c;
    cmd_o.bank_sel = b;
    cmd_o.addr = a;
    dqm_o = m;
    dq_o = d;
    @(posedge mclk_i);
    #1;
  endtask : step
  // released data lines flip so a stale byte never looks valid
  task idle();
    step(4'h7, 2'h0, 12'h000, 1'b1, 1'b0, ~dq_o);
  endtask : idle
endmodule : sdc_ctl_model
`default_nettype wire

// [sdc_map.svh]
// Purpose: constants of the sdram command and bank state logic
// Assumes: one 20 MHz clock, inputs from logic on the same clock
// Notes:   times in ns, RP and RC cycle counts derived from the clock period, mode set count fixed at 2
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH

`define SDC_CLK_PERIOD_NS 50
`define SDC_T_RP_NS       20
`define SDC_T_RC_NS       65
`define SDC_RP_CYC ((`SDC_T_RP_NS + `SDC_CLK_PERIOD_NS - 1) / `SDC_CLK_PERIOD_NS)
`define SDC_RC_CYC ((`SDC_T_RC_NS + `SDC_CLK_PERIOD_NS - 1) / `SDC_CLK_PERIOD_NS)
`define SDC_MRS_CYC       2

`define SDC_AP_BIT        10
`define SDC_COL_MSB       7
`define SDC_MR_BL_LSB     0
`define SDC_MR_BL_MSB     2
`define SDC_MR_CL_LSB     4
`define SDC_MR_CL_MSB     6
`define SDC_MR_RST        12'h020
`define SDC_BL_FULL       3'h7
`define SDC_CL3_CODE      3'h3
`define SDC_PAGE_LEN      9'h100

`endif

// [sdc_pkg.sv]
// Purpose: types of the sdram command and bank state logic
// Assumes: nothing
// Notes:   constants live in sdc_map.svh
`default_nettype none
package sdc_pkg;
  typedef enum logic [3:0] {
    sdc_mode_set, sdc_refresh, sdc_precharge, sdc_activate,
    sdc_write, sdc_read, sdc_stop, sdc_nop, sdc_deselect
  } sdc_cmd_t;

  typedef enum logic [1:0] {bk_idle, bk_active, bk_prech} sdc_bank_st_t;

  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bank_sel;
    logic [11:0] addr;
  } sdc_cmd_pins_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sdc_rd_beat_t;
endpackage : sdc_pkg
`default_nettype wire

// [sdc_rd_pipe.sv]
// Purpose: read latency delay line
// Assumes: adv_i low freezes every stage
// Notes:   tap selects how many edges the beat waited
`default_nettype none
module sdc_rd_pipe #(
  parameter int W     = 9,
  parameter int DEPTH = 2
) (
  input  wire logic                     mclk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic                     adv_i,
  input  wire logic [W-1:0]             din_i,
  input  wire logic [$clog2(DEPTH)-1:0] sel_i,
  output logic      [W-1:0]             dout_o
);
  logic [W-1:0] st_q [DEPTH];

  for (genvar g = 0; g < DEPTH; g++) begin : g_st
    always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
        st_q[g] <= '0;
      end else if (adv_i) begin
        st_q[g] <= (g == 0) ? din_i : st_q[(g == 0) ? 0 : g - 1];
      end
    end
  end

  assign dout_o = st_q[sel_i];
endmodule : sdc_rd_pipe
`default_nettype wire

// [test_sdram_command_state_logic.sv]
// Purpose: directed test of sdc_core
// Assumes: 20 MHz clock, one command per cycle
// Notes:   the controller model issues every command
`default_nettype none
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module test_sdram_command_state_logic;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] C_MRS = 4'h0;
  localparam logic [3:0] C_REF = 4'h1;
  localparam logic [3:0] C_PRE = 4'h2;
  localparam logic [3:0] C_ACT = 4'h3;
  localparam logic [3:0] C_WR  = 4'h4;
  localparam logic [3:0] C_RD  = 4'h5;
  localparam logic [3:0] C_STP = 4'h6;
  localparam logic [3:0] C_NOP = 4'h7;
  localparam logic [3:0] C_DES = 4'h8;
  logic                   mclk = 1'b0;
  logic                   sys_rst = 1'b1;
  logic                   cke;
  sdc_pkg::sdc_cmd_pins_t cmd;
  logic                   dqm;
  logic [7:0]             dq_w;
  logic [7:0]             dq_r;
  logic                   dq_oe_n;
  logic [3:0]             bank_open;
  logic                   burst_act, susp, pdn, srf, busy, ill;
  logic [7:0]             exp_mem [4];
  int                     err_count = 0;
  int                     checks = 0;
  int                     cycles = 0;

  always #25 mclk = ~mclk;
  sdc_ctl_model ctl (.mclk_i(mclk), .cke_o(cke), .cmd_o(cmd), .dqm_o(dqm), .dq_o(dq_w));
  sdc_core dut (
    .mclk_i(mclk), .sys_rst_i(sys_rst), .cke_i(cke), .cmd_i(cmd), .dqm_i(dqm),
    .dq_i(dq_w), .dq_o(dq_r), .dq_oe_n_o(dq_oe_n), .bank_open_o(bank_open),
    .burst_active_o(burst_act), .suspend_o(susp), .power_down_o(pdn),
    .self_refresh_o(srf), .busy_o(busy), .illegal_o(ill));

  task final_report();
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task done(input string n);
    $display("test %s done", n);
  endtask : done

  // read of bank 1 column 10h cut cl-1 cycles later, so cl-1 beats were pushed and still leave
  task rd_cut(input int cl, input logic [3:0] cut);
    ctl.step(C_ACT, 2'h1, 12'h005, 1'b1, 1'b0, 8'h00);
    ctl.step(C_RD, 2'h1, 12'h010, 1'b1, 1'b0, 8'h00);
    for (int t = 1; t <= 2 * cl - 2; t++) begin
      if (t == cl - 1) ctl.step(cut, 2'h1, 12'h000, 1'b1, 1'b0, 8'h00);
      else ctl.idle();
      `CHK(dq_oe_n, !(t >= cl - 1 && t <= 2 * cl - 3), "cut oe")
      if (t >= cl - 1 && t <= 2 * cl - 3) `CHK(dq_r, exp_mem[t - cl + 1], "cut data")
    end
  endtask : rd_cut

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 500) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    repeat (5) @(negedge mclk);
    sys_rst = 1'b0;
    `CHK(dq_oe_n, 1'b1, "reset oe")
    `CHK(bank_open, 4'h0, "reset banks")
    done("reset");
    ctl.step(C_MRS, 2'h0, 12'h002, 1'b1, 1'b0, 8'h00);
    `CHK(busy, 1'b1, "mrs busy")
    ctl.idle();
    `CHK(busy, 1'b0, "mrs done")
    ctl.step(C_ACT, 2'h1, 12'h005, 1'b1, 1'b0, 8'h00);
    `CHK(bank_open, 4'h2, "act")
    for (int w = 0; w < 2; w++) begin
      for (int i = 0; i < 4; i++) begin
        logic [7:0] d;
        logic       m;
        d = (w == 1) ? 8'hA0 + 8'(i) : 8'h10 + 8'(i);
        m = (w == 1) && (i == 2);
        ctl.step((i == 0) ? C_WR : C_NOP, 2'h1, 12'h010, 1'b1, m, d);
        if (!m) exp_mem[i] = d;
      end
      ctl.idle();
    end
    ctl.step(C_RD, 2'h1, 12'h010, 1'b1, 1'b0, 8'h00);
    `CHK(burst_act, 1'b1, "burst on")
    ctl.step(C_NOP, 2'h0, 12'h000, 1'b1, 1'b1, 8'h00);
    `CHK(dq_oe_n, 1'b0, "rd first oe")
    `CHK(dq_r, exp_mem[0], "rd first data")
    for (int t = 3; t <= 6; t++) begin
      ctl.idle();
      `CHK(dq_oe_n, t == 3 || t == 6, "rd oe")
      if (t != 3 && t != 6) `CHK(dq_r, exp_mem[t - 2], "rd data")
    end
    done("write_read");
    for (int k = 0; k < 3; k++) begin
      ctl.step(k == 0 ? C_ACT : (k == 1 ? C_RD : C_REF), k == 1 ? 2'h0 : 2'h1, 12'h005,
               1'b1, 1'b0, 8'h00);
      `CHK(ill, 1'b1, "refused")
    end
    ctl.idle();
    `CHK(bank_open, 4'h2, "banks kept")
    ctl.step(C_NOP, 2'h0, 12'h000, 1'b0, 1'b0, 8'h00);
    `CHK(susp, 1'b1, "suspend")
    ctl.step(C_NOP, 2'h0, 12'h000, 1'b1, 1'b0, 8'h00);
    `CHK(susp, 1'b0, "resume")
    ctl.step(C_PRE, 2'h1, 12'h000, 1'b1, 1'b0, 8'h00);
    `CHK(bank_open, 4'h0, "pre one")
    done("illegal_suspend");
    rd_cut(2, C_PRE);
    ctl.step(C_MRS, 2'h0, 12'h032, 1'b1, 1'b0, 8'h00);
    ctl.idle();
    rd_cut(3, C_STP);
    ctl.step(C_ACT, 2'h2, 12'h001, 1'b1, 1'b0, 8'h00);
    `CHK(bank_open, 4'h6, "two open")
    ctl.step(C_PRE, 2'h0, 12'h400, 1'b1, 1'b0, 8'h00);
    `CHK(bank_open, 4'h0, "pre all")
    done("cut");
    ctl.step(C_REF, 2'h0, 12'h000, 1'b1, 1'b0, 8'h00);
    `CHK(busy, 1'b1, "ref busy")
    ctl.idle();
    `CHK(busy, 1'b0, "ref done")
    for (int k = 0; k < 3; k++) begin
      ctl.step(C_DES, 2'h0, 12'h000, k == 2, 1'b0, 8'h00);
      `CHK(pdn, k != 2, "power down")
    end
    for (int k = 0; k < 3; k++) begin
      ctl.step(k == 0 ? C_REF : C_NOP, 2'h0, 12'h000, k == 2, 1'b0, 8'h00);
      `CHK(srf, k != 2, "self refresh")
    end
    repeat (2) ctl.idle();
    repeat (2) begin
      ctl.step(C_REF, 2'h0, 12'h000, 1'b1, 1'b0, 8'h00);
      ctl.idle();
    end
    ctl.step(C_REF, 2'h0, 12'h000, 1'b0, 1'b0, 8'h00);
    ctl.step(C_ACT, 2'h0, 12'h005, 1'b1, 1'b0, 8'h00);
    `CHK(ill, 1'b1, "bad exit")
    `CHK(bank_open, 4'h0, "bad exit bank")
    done("power");
    final_report();
  end
endmodule : test_sdram_command_state_logic
`default_nettype wire
